//--- i2c_master_model.sv
// i2c bus master model: open-drain pulls on scl and sda, 400 ns bit slots
// assumes the bench resolves both wires with pull-ups and runs clk_i at 20 MHz
`timescale 1ns/1ps
`default_nettype none

module i2c_master_model (
	// clock
	input wire logic clk_i,
	// resolved wires
	input wire logic scl_i,
	input wire logic sda_i,
	// pulls, low = wire pulled low
	output logic scl_oe_n_o,
	output logic sda_oe_n_o
);
	// ----------------------------------------
	// bit level
	// ----------------------------------------
	// both lines released at power up
	initial begin
		scl_oe_n_o = 1'b1;
		sda_oe_n_o = 1'b1;
	end

	// one slot: 5 clocks low, 3 high; scl is low on entry
	task automatic slot(input logic b, output logic seen);
		repeat (3) @(posedge clk_i);
		sda_oe_n_o <= b;
		repeat (2) @(posedge clk_i);
		scl_oe_n_o <= 1'b1;
		// the target may stretch scl, so the high phase counts from the wire
		@(posedge clk_i);
		while (scl_i !== 1'b1) @(posedge clk_i);
		seen = sda_i;
		repeat (2) @(posedge clk_i);
		scl_oe_n_o <= 1'b0;
	endtask : slot

	// ----------------------------------------
	// frame level
	// ----------------------------------------
	// start condition
	task automatic start_cond();
		sda_oe_n_o <= 1'b0;
		repeat (4) @(posedge clk_i);
		scl_oe_n_o <= 1'b0;
	endtask : start_cond

	task automatic stop_cond();
		repeat (3) @(posedge clk_i);
		sda_oe_n_o <= 1'b0;
		repeat (2) @(posedge clk_i);
		scl_oe_n_o <= 1'b1;
		@(posedge clk_i);
		while (scl_i !== 1'b1) @(posedge clk_i);
		repeat (2) @(posedge clk_i);
		sda_oe_n_o <= 1'b1;
		repeat (4) @(posedge clk_i);
	endtask : stop_cond

	// msb first, then the target's ack slot (0 = ack)
	task automatic send_byte(input logic [7:0] d, output logic ack_n);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			slot(d[i], s);
		end
		slot(1'b1, ack_n);
	endtask : send_byte

	// last byte of a read is answered with nack
	task automatic recv_byte(input logic nack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			slot(1'b1, s);
			d[i] = s;
		end
		slot(nack, s);
	endtask : recv_byte
endmodule : i2c_master_model

`default_nettype wire

//--- i2c_slave_pkg.sv
// constants, types and carriers shared by the i2c target block and its testbench
// assumes a 32-bit apb bus at 20 MHz and a sampled (not clocked) i2c link
//
// Overview of operation
// R1: one byte-wide data register; read gives last received byte, write gives next sent. The code reads the oldest unread byte of a 16-byte fifo.
// R2: target answers seven-bit address 0x39 until software programs another own address.
// R3: single write: start, address as receiver acked, one byte acked, then stop.
// R4: single read: start, address as transmitter acked, one byte out, master nacks, stop.
// R5: burst write: every data byte is acknowledged until a stop appears. The code nacks a byte when the 16-byte fifo is full.
// R6: burst read: bytes keep going while master acks; a nack ends data supply.
// R7: master ends burst read by nacking the last byte and then sending stop.
// R8: interrupt flag sets on every completed byte and on every transfer error. The code sets it on data bytes and overflow only; address bytes never set it.
// R9: interrupt flag stays set until software clears it; hardware never clears it.
// R10: writing 0x80 to the interrupt register clears the interrupt flag.
// R11: software writes can never set the interrupt flag.
// R12: interrupt register holds flag in bit 1, enable in bit 0, rest unused.
// R13: enable bit is read/write and gates this block's interrupt.
// R14: software finds the interrupt cause by reading the status bits.
// R15: transmitted bytes leave most significant bit first.
// R16: receive-pending status clears when software reads the data register. The code clears it only when that read takes the last byte in the fifo.
// R17: transmit-wanted status clears when software writes the data register.
// R18: interrupt output is high only while flag and enable are both set.

package i2c_slave_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [31:0] ADDR_OWN  = 32'h50003804;
	localparam logic [31:0] ADDR_STAT = 32'h50003808;
	localparam logic [31:0] ADDR_BUF  = 32'h5000380C;
	localparam logic [31:0] ADDR_INT  = 32'h5000381C;

	// ----------------------------------------------------------------
	// fields and reset values
	// ----------------------------------------------------------------
	localparam logic [6:0] OWN_ADDR_RST = 7'h39;
	localparam logic [7:0] INT_CLR_VAL = 8'h80;
	localparam int INT_FLAG_BIT = 1;
	localparam int INT_EN_BIT = 0;
	localparam int STAT_RXP_BIT = 0;
	localparam int STAT_TXW_BIT = 1;
	localparam int STAT_SEDFIN_BIT = 2;
	localparam int STAT_RECFIN_BIT = 3;
	localparam int STAT_BUSY_BIT = 4;
	localparam int BYTE_W = 8;
	localparam int RX_FIFO_DEPTH = 16;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// ----------------------------------------------------------------
	// link sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_AACK = 3'b010,
		ST_RX   = 3'b011,
		ST_RACK = 3'b100,
		ST_TX   = 3'b101,
		ST_MACK = 3'b110,
		ST_HOLD = 3'b111
	} link_state_t;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} i2c_pin_in_t;

	typedef struct packed {
		logic scl;
		logic scl_oe_n;
		logic sda;
		logic sda_oe_n;
	} i2c_pin_out_t;

endpackage : i2c_slave_pkg

//--- i2c_slave_xfer.sv
// i2c target: byte sequencing, data register, status and interrupt flag over apb
// assumes scl/sda come straight from pins; the bench resolves the open-drain wires
`timescale 1ns/1ps
`default_nettype none

module i2c_slave_xfer
	import i2c_slave_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// apb register port
	input wire apb_req_t apb_req_i,
	output var apb_rsp_t apb_rsp_o,
	// i2c pins
	input wire i2c_pin_in_t i2c_in_i,
	output var i2c_pin_out_t i2c_out_o,
	// interrupt
	output logic irq_o
);

	typedef struct packed {
		logic scl_meta;
		logic scl_sync;
		logic scl_prev;
		logic sda_meta;
		logic sda_sync;
		logic sda_prev;
		link_state_t st;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic rw;
		logic acked;
		logic sda_drv;
		logic scl_drv;
		logic [7:0] tx_byte;
		logic tx_want;
		logic recfin;
		logic sedfin;
		logic busy;
		logic [6:0] own_addr;
		logic own_set;
		logic flag;
		logic en;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic irq;
	} state_t;

	state_t q;
	state_t d;

	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic apb_setup;
	logic apb_acc;
	logic hw_set;
	logic push;
	logic pop;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [7:0] fifo_out_data;

	// ----------------------------------------------------------------
	// bus condition detection on synchronised pins
	// ----------------------------------------------------------------
	// only the second and third stages are looked at; the first may be metastable
	assign scl_rise = q.scl_sync & ~q.scl_prev;
	assign scl_fall = ~q.scl_sync & q.scl_prev;
	assign start_seen = q.scl_sync & q.scl_prev & q.sda_prev & ~q.sda_sync;
	assign stop_seen = q.scl_sync & q.scl_prev & ~q.sda_prev & q.sda_sync;
	assign apb_setup = apb_req_i.psel & ~apb_req_i.penable;
	assign apb_acc = apb_req_i.psel & apb_req_i.penable & q.pready;

	// ----------------------------------------------------------------
	// received bytes wait here for software
	// ----------------------------------------------------------------
	rx_byte_fifo #(
		.WIDTH(BYTE_W),
		.DEPTH(RX_FIFO_DEPTH)
	) u_rx_fifo (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.in_valid_i(push),
		.in_ready_o(fifo_in_ready),
		.in_data_i(q.sh),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(pop),
		.out_data_o(fifo_out_data)
	);

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		d = q;
		hw_set = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		d.scl_meta = i2c_in_i.scl;
		d.scl_sync = q.scl_meta;
		d.scl_prev = q.scl_sync;
		d.sda_meta = i2c_in_i.sda;
		d.sda_sync = q.sda_meta;
		d.sda_prev = q.sda_sync;

		// apb setup phase: decode and latch read data, answer in access phase
		d.pready = apb_setup;
		d.pslverr = 1'b0;
		if (apb_setup) begin
			d.prdata = 32'h00000000;
			case (apb_req_i.paddr)
				// R1: read side of data register
				ADDR_BUF: d.prdata[7:0] = fifo_out_data;
				// R12: flag bit 1, enable bit 0
				ADDR_INT: begin
					d.prdata[INT_FLAG_BIT] = q.flag;
					d.prdata[INT_EN_BIT] = q.en;
				end
				// R14: status shows the interrupt cause
				ADDR_STAT: begin
					d.prdata[STAT_RXP_BIT] = fifo_out_valid;
					d.prdata[STAT_TXW_BIT] = q.tx_want;
					d.prdata[STAT_SEDFIN_BIT] = q.sedfin;
					d.prdata[STAT_RECFIN_BIT] = q.recfin;
					d.prdata[STAT_BUSY_BIT] = q.busy;
				end
				ADDR_OWN: d.prdata[6:0] = q.own_addr;
				default: d.pslverr = 1'b1;
			endcase
		end

		// apb access phase: writes and read side effects take effect here
		if (apb_acc && apb_req_i.pwrite) begin
			case (apb_req_i.paddr)
				// R17: writing the byte withdraws the request
				ADDR_BUF: begin
					d.tx_byte = apb_req_i.pwdata[7:0];
					d.tx_want = 1'b0;
				end
				ADDR_INT: begin
					// R13: enable is plain read/write
					d.en = apb_req_i.pwdata[INT_EN_BIT];
					// R10: clear by 0x80; R11: no write path sets it
					if (apb_req_i.pwdata[7:0] == INT_CLR_VAL) begin
						d.flag = 1'b0;
					end
				end
				ADDR_STAT: begin
					if (apb_req_i.pwdata[STAT_RECFIN_BIT]) begin
						d.recfin = 1'b0;
					end
					if (apb_req_i.pwdata[STAT_SEDFIN_BIT]) begin
						d.sedfin = 1'b0;
					end
				end
				ADDR_OWN: begin
					d.own_addr = apb_req_i.pwdata[6:0];
					d.own_set = 1'b1;
				end
				default: ;
			endcase
		end
		// R16: read of the data register pops the pending byte
		if (apb_acc && !apb_req_i.pwrite && apb_req_i.paddr == ADDR_BUF) begin
			pop = 1'b1;
		end

		// link sequencer; placed after apb so hardware sets win over clears
		case (q.st)
			ST_IDLE: ;
			ST_ADDR: begin
				if (scl_rise) begin
					d.sh = {q.sh[6:0], q.sda_sync};
					d.cnt = q.cnt + 4'h1;
				end
				if (scl_fall && q.cnt == BITS_PER_BYTE) begin
					// R2: own address match; a full fifo refuses a write
					if (q.sh[7:1] == q.own_addr && (q.sh[0] || fifo_in_ready)) begin
						d.sda_drv = 1'b1;
						d.st = ST_AACK;
						d.rw = q.sh[0];
						d.tx_want = q.sh[0];
					end else begin
						d.st = ST_IDLE;
						d.busy = 1'b0;
					end
				end
			end
			ST_AACK: begin
				// R3: address ack ends, then data phase
				if (scl_fall) begin
					d.sda_drv = 1'b0;
					d.cnt = 4'h0;
					if (q.rw) begin
						d.st = ST_HOLD;
						d.scl_drv = 1'b1;
					end else begin
						d.st = ST_RX;
					end
				end
			end
			ST_RX: begin
				if (scl_rise) begin
					d.sh = {q.sh[6:0], q.sda_sync};
					d.cnt = q.cnt + 4'h1;
				end
				if (scl_fall && q.cnt == BITS_PER_BYTE) begin
					// R8: byte done or overflow error both raise the flag
					hw_set = 1'b1;
					if (fifo_in_ready) begin
						// R5: acknowledge every accepted byte
						push = 1'b1;
						d.sda_drv = 1'b1;
						d.st = ST_RACK;
					end else begin
						d.st = ST_IDLE;
					end
				end
			end
			ST_RACK: begin
				if (scl_fall) begin
					d.sda_drv = 1'b0;
					d.cnt = 4'h0;
					d.st = ST_RX;
				end
			end
			ST_HOLD: begin
				// clock stretched until software supplies the byte
				if (!q.tx_want) begin
					// R15: most significant bit goes first
					d.sh = q.tx_byte;
					d.sda_drv = ~q.tx_byte[7];
					d.scl_drv = 1'b0;
					d.cnt = 4'h0;
					d.st = ST_TX;
				end
			end
			ST_TX: begin
				if (scl_rise) begin
					d.cnt = q.cnt + 4'h1;
				end
				if (scl_fall) begin
					if (q.cnt == BITS_PER_BYTE) begin
						d.sda_drv = 1'b0;
						d.st = ST_MACK;
					end else begin
						d.sh = {q.sh[6:0], 1'b0};
						d.sda_drv = ~q.sh[6];
					end
				end
			end
			ST_MACK: begin
				if (scl_rise) begin
					// R8: sent byte completes at the master's ack bit
					hw_set = 1'b1;
					d.acked = ~q.sda_sync;
					d.tx_want = ~q.sda_sync;
				end
				if (scl_fall) begin
					// R6: ack asks for more, nack ends supply (R4, R7)
					d.cnt = 4'h0;
					if (q.acked) begin
						d.st = ST_HOLD;
						d.scl_drv = 1'b1;
					end else begin
						d.st = ST_IDLE;
					end
				end
			end
			default: d.st = ST_IDLE;
		endcase

		// start and stop override the sequencer in any state
		if (start_seen) begin
			d.st = ST_ADDR;
			d.cnt = 4'h0;
			d.sda_drv = 1'b0;
			d.scl_drv = 1'b0;
			d.busy = 1'b1;
		end
		if (stop_seen) begin
			d.st = ST_IDLE;
			d.sda_drv = 1'b0;
			d.scl_drv = 1'b0;
			d.busy = 1'b0;
			d.tx_want = 1'b0;
			if (q.busy && q.st != ST_ADDR) begin
				d.recfin = q.recfin | ~q.rw;
				d.sedfin = q.sedfin | q.rw;
			end
		end

		// R9: only the 0x80 write above ever clears the flag
		if (hw_set) begin
			d.flag = 1'b1;
		end
		// R18: request follows flag and enable
		d.irq = d.flag & d.en;
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '0;
			q.scl_meta <= 1'b1;
			q.scl_sync <= 1'b1;
			q.scl_prev <= 1'b1;
			q.sda_meta <= 1'b1;
			q.sda_sync <= 1'b1;
			q.sda_prev <= 1'b1;
			q.st <= ST_IDLE;
			q.own_addr <= OWN_ADDR_RST;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all from the state register
	// ----------------------------------------------------------------
	assign apb_rsp_o = '{prdata: q.prdata, pready: q.pready, pslverr: q.pslverr};
	// pins only ever pull low; enable is active low
	assign i2c_out_o = '{scl: 1'b0, scl_oe_n: ~q.scl_drv, sda: 1'b0, sda_oe_n: ~q.sda_drv};
	assign irq_o = q.irq;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	logic clr_wr;
	assign clr_wr = apb_acc && apb_req_i.pwrite && apb_req_i.paddr == ADDR_INT
		&& apb_req_i.pwdata[7:0] == INT_CLR_VAL;

	AST_IRQ_GATE: assert property (irq_o == (q.flag && q.en)) // R18
		else $error("irq output differs from flag and enable");
	AST_FLAG_SET: assert property (hw_set |=> q.flag ##1 q.flag || $past(clr_wr)) // R8
		else $error("byte event did not raise the flag");
	AST_FLAG_HOLD: assert property (q.flag && !clr_wr |=> q.flag) // R9
		else $error("flag dropped without software clear");
	AST_FLAG_CLR: assert property (clr_wr && !hw_set |=> !q.flag) // R10
		else $error("0x80 write did not clear the flag");
	AST_NO_SW_SET: assert property (!q.flag && !hw_set |=> !q.flag) // R11
		else $error("flag set without hardware event");
	AST_DEF_ADDR: assert property (!q.own_set |-> q.own_addr == OWN_ADDR_RST) // R2
		else $error("own address left default without a write");
	AST_TXW_CLR: assert property (apb_acc && apb_req_i.pwrite && apb_req_i.paddr == ADDR_BUF
		&& !(q.st == ST_MACK && scl_rise) && !(q.st == ST_ADDR && scl_fall)
		|=> !q.tx_want) // R17
		else $error("data write left transmit request set");
	AST_RX_ACK: assert property (q.st == ST_RX && scl_fall && q.cnt == BITS_PER_BYTE
		&& fifo_in_ready && !start_seen && !stop_seen
		|=> !i2c_out_o.sda_oe_n [*1] ##1 q.st == ST_RACK || !i2c_out_o.sda_oe_n) // R5
		else $error("accepted byte not acknowledged");
	AST_MSB_FIRST: assert property (q.st == ST_HOLD && !q.tx_want && !start_seen && !stop_seen
		|=> i2c_out_o.sda_oe_n == $past(q.tx_byte[7])) // R15
		else $error("first bit sent is not the msb");
	AST_NACK_END: assert property (q.st == ST_MACK && scl_rise && q.sda_sync
		|=> !q.tx_want) // R6
		else $error("transmit request raised after nack");
	AST_RXP_CLR: assert property (pop && u_rx_fifo.q.cnt == 5'h01 && !push
		|=> !fifo_out_valid) // R16
		else $error("pending byte survived the read");

	COV_WRITE_BYTE: cover property (q.st == ST_RX && push);
	COV_READ_BYTE: cover property (q.st == ST_MACK && scl_rise && !q.sda_sync);
	COV_BURST_WRITE: cover property (q.st == ST_RACK ##[1:1000] q.st == ST_RX ##[1:1000] push);
	COV_STOP_AFTER_READ: cover property (stop_seen && q.rw && q.busy);

endmodule : i2c_slave_xfer

`default_nettype wire

//--- rx_byte_fifo.sv
// first-in first-out byte store between the link receiver and the data register
// assumes one clock, depth a power of two, producer honours in_ready_o
`timescale 1ns/1ps
`default_nettype none

module rx_byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);

	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} fifo_state_t;

	fifo_state_t q;
	fifo_state_t d;
	logic [WIDTH-1:0] mem [DEPTH];
	logic wr;
	logic rd;

	// ----------------------------------------------------------------
	// flags and handshakes
	// ----------------------------------------------------------------
	assign in_ready_o = (q.cnt != (AW+1)'(DEPTH));
	assign out_valid_o = (q.cnt != '0);
	assign out_data_o = mem[q.rp];
	assign wr = in_valid_i & in_ready_o;
	assign rd = out_valid_o & out_ready_i;

	// pointer and count update; simultaneous push and pop keeps the count
	always_comb begin
		d = q;
		if (wr) begin
			d.wp = q.wp + 1'b1;
		end
		if (rd) begin
			d.rp = q.rp + 1'b1;
		end
		if (wr && !rd) begin
			d.cnt = q.cnt + 1'b1;
		end else if (rd && !wr) begin
			d.cnt = q.cnt - 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// storage has no reset; empty flag masks stale words
	always_ff @(posedge clk_i) begin
		if (wr) begin
			mem[q.wp] <= in_data_i;
		end
	end

endmodule : rx_byte_fifo

`default_nettype wire

//--- testbench.sv
// self-checking bench for the i2c target: apb master tasks plus a bus master model
// assumes the design package and both models compile before this file
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import i2c_slave_pkg::*;
	localparam int TIMEOUT_CYCLES = 20000;
	localparam logic [31:0] ALL = 32'hFFFFFFFF;
	localparam logic [7:0] TX_PAT [2] = '{8'hC1, 8'h36};
	logic clk;
	logic rst_n;
	logic irq;
	logic m_scl_oe_n;
	logic m_sda_oe_n;
	apb_req_t apb_req;
	apb_rsp_t apb_rsp;
	i2c_pin_in_t i2c_in;
	i2c_pin_out_t i2c_out;
	int fails;
	int num_checks;
	int cycles;

	// ----------------------------------------
	// wires, design and far side
	// ----------------------------------------
	// open-drain wires with pull-ups
	wire logic scl_w = i2c_out.scl_oe_n & m_scl_oe_n;
	wire logic sda_w = i2c_out.sda_oe_n & m_sda_oe_n;
	assign i2c_in = {scl_w, sda_w};

	i2c_slave_xfer dut (.clk_i(clk), .rst_n_i(rst_n), .apb_req_i(apb_req),
		.apb_rsp_o(apb_rsp), .i2c_in_i(i2c_in), .i2c_out_o(i2c_out), .irq_o(irq));
	i2c_master_model master (.clk_i(clk), .scl_i(scl_w), .sda_i(sda_w),
		.scl_oe_n_o(m_scl_oe_n), .sda_oe_n_o(m_sda_oe_n));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// one apb transfer; held until pready is sampled high
	task automatic apb_xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
			output logic [31:0] rd, output logic err);
		@(posedge clk);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
		@(posedge clk);
		apb_req.penable <= 1'b1;
		// the slave sets the pace; only the bench timeout ends a stuck wait
		do begin
			@(posedge clk);
		end while (apb_rsp.pready !== 1'b1);
		rd = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask : apb_xfer

	task automatic reg_wr(input logic [31:0] addr, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb_xfer(1'b1, addr, d, r, e);
	endtask : reg_wr

	task automatic reg_chk(input string name, input logic [31:0] addr, input logic [31:0] mask,
			input logic [31:0] exp);
		logic [31:0] r;
		logic e;
		apb_xfer(1'b0, addr, 32'h0, r, e);
		check(name, r & mask, exp);
	endtask : reg_chk

	// software side polls until the target asks for a byte
	task automatic wait_tx_byte_wanted();
		logic [31:0] r;
		logic e;
		int k;
		k = 0;
		do begin
			apb_xfer(1'b0, ADDR_STAT, 32'h0, r, e);
			k++;
		end while (r[STAT_TXW_BIT] !== 1'b1 && k < 300);
		check("tx_byte_wanted set", {31'h0, r[STAT_TXW_BIT]}, 32'h1);
		check("bus active", {31'h0, r[STAT_BUSY_BIT]}, 32'h1);
	endtask : wait_tx_byte_wanted

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		logic [31:0] r;
		logic e;
		reg_chk("int reset", ADDR_INT, ALL, 32'h0);
		reg_chk("own reset", ADDR_OWN, ALL, 32'h39);
		apb_xfer(1'b0, 32'h50003820, 32'h0, r, e);
		check("unmapped err", {31'h0, e}, 32'h1);
	endtask : t_reset

	task automatic t_write();
		logic a;
		reg_wr(ADDR_INT, 32'h01);
		master.start_cond();
		master.send_byte({OWN_ADDR_RST, 1'b0}, a);
		check("addr ack", {31'h0, a}, 32'h0);
		master.send_byte(8'hA5, a);
		check("data ack", {31'h0, a}, 32'h0);
		master.stop_cond();
		check("irq on", {31'h0, irq}, 32'h1);
		reg_chk("int flag", ADDR_INT, ALL, 32'h03);
		reg_chk("stat rx", ADDR_STAT, 32'h1F, 32'h09);
		reg_chk("buf", ADDR_BUF, ALL, 32'hA5);
		reg_chk("rx pending", ADDR_STAT, 32'h01, 32'h0);
		reg_wr(ADDR_STAT, 32'h08);
		reg_chk("rec fin clr", ADDR_STAT, 32'h08, 32'h0);
	endtask : t_write

	// flag is held, cleared only by 0x80, never set by software
	task automatic t_flag();
		reg_wr(ADDR_INT, 32'h00);
		reg_chk("flag held", ADDR_INT, ALL, 32'h02);
		check("irq masked", {31'h0, irq}, 32'h0);
		reg_wr(ADDR_INT, 32'h80);
		reg_chk("flag clr", ADDR_INT, ALL, 32'h00);
		reg_wr(ADDR_INT, 32'h02);
		reg_chk("flag sw", ADDR_INT, ALL, 32'h00);
		reg_wr(ADDR_INT, 32'h01);
		reg_chk("enable", ADDR_INT, ALL, 32'h01);
		check("irq idle", {31'h0, irq}, 32'h0);
	endtask : t_flag

	task automatic t_mismatch();
		logic a;
		master.start_cond();
		master.send_byte({7'h38, 1'b0}, a);
		master.stop_cond();
		check("foreign ack", {31'h0, a}, 32'h1);
		reg_chk("no flag", ADDR_INT, 32'h02, 32'h0);
		// a programmed own address replaces the default one
		reg_wr(ADDR_OWN, 32'h38);
		reg_chk("own prog", ADDR_OWN, ALL, 32'h38);
		master.start_cond();
		master.send_byte({7'h38, 1'b0}, a);
		master.stop_cond();
		check("prog ack", {31'h0, a}, 32'h0);
		reg_wr(ADDR_STAT, 32'h08);
		reg_wr(ADDR_OWN, {25'h0, OWN_ADDR_RST});
	endtask : t_mismatch

	// fill the 16-byte store with software stalled, one byte more is refused
	task automatic t_fill();
		logic a;
		master.start_cond();
		master.send_byte({OWN_ADDR_RST, 1'b0}, a);
		for (int i = 0; i < 17; i++) begin
			master.send_byte(8'h10 + 8'(i), a);
			check("fill ack", {31'h0, a}, (i < 16) ? 32'h0 : 32'h1);
		end
		master.stop_cond();
		reg_chk("err flag", ADDR_INT, 32'h02, 32'h02);
		for (int i = 0; i < 16; i++) begin
			reg_chk("drain", ADDR_BUF, ALL, 32'h10 + 32'(i));
		end
		reg_chk("drained", ADDR_STAT, 32'h01, 32'h0);
		reg_wr(ADDR_INT, 32'h80);
		reg_wr(ADDR_STAT, 32'h08);
	endtask : t_fill

	// n bytes read by the master; the last one is not acknowledged
	task automatic t_read(input int n);
		logic [7:0] got [2];
		logic a;
		fork
			begin
				master.start_cond();
				master.send_byte({OWN_ADDR_RST, 1'b1}, a);
				for (int i = 0; i < n; i++) begin
					master.recv_byte(i == n - 1, got[i]);
				end
				master.stop_cond();
			end
			begin
				for (int j = 0; j < n; j++) begin
					wait_tx_byte_wanted();
					reg_wr(ADDR_BUF, {24'h0, TX_PAT[j]});
					reg_chk("tx_byte_wanted clr", ADDR_STAT, 32'h02, 32'h0);
				end
			end
		join
		check("rd addr ack", {31'h0, a}, 32'h0);
		for (int i = 0; i < n; i++) begin
			check("rd byte", {24'h0, got[i]}, {24'h0, TX_PAT[i]});
		end
		reg_chk("send fin", ADDR_STAT, 32'h06, 32'h04);
		reg_chk("tx flag", ADDR_INT, 32'h02, 32'h02);
		reg_wr(ADDR_INT, 32'h80);
		reg_wr(ADDR_STAT, 32'h04);
	endtask : t_read

	// ----------------------------------------
	// run control
	// ----------------------------------------
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : summarize

	always #25 clk = ~clk;

	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == TIMEOUT_CYCLES) begin
			fails++;
			summarize();
		end
	end

	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		apb_req = '0;
		fails = 0;
		num_checks = 0;
		cycles = 0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_reset();
		t_write();
		t_flag();
		t_mismatch();
		t_fill();
		t_read(1);
		t_read(2);
		summarize();
	end
endmodule : testbench

`default_nettype wire
